// >>> rtl/ccdtg_defs.svh
// constants of the ccd sync and horizontal clock timing core
// Contract
// - mode bit 0 slave sync, 1 master; level bit 0 low, 1 high active
// - master line sync rises at the 13-bit position in sync edge register
// - master field sync rises at the 12-bit upper field of that register
// - input-divide bit 1 halves the input clock, 0 leaves it undivided
// - first pair edges from two 6-bit fields; bit 16 zero inverts
// - second pair edges from two 6-bit fields; bit 16 zero inverts
// - last-stage clock edges from two 6-bit fields; bit 16 zero inverts
// - reset-gate edges from two 6-bit fields, fall default 10; bit 16 zero inverts
// - first-pair retime bit delays blanking toggles by one pixel
// - bit 1 retimes blanking for the second pair to its clock
// - bit 2 retimes blanking for the last-stage clock
// - blanking affects the last-stage clock only when bit 3 is 1
// - during blanking the three blanked clocks run at pixel rate over twice the width code
// - field-updated values apply at the line held in update-line register
// - update-hold bit 1 keeps working values, pending writes wait
`ifndef CCDTG_DEFS_SVH
`define CCDTG_DEFS_SVH
`define CCDTG_AW 8
`define CCDTG_DW 25
`define CCDTG_A_UPDLINE 8'h18
`define CCDTG_A_HOLD 8'h19
`define CCDTG_A_MODE 8'h20
`define CCDTG_A_LEVEL 8'h21
`define CCDTG_A_SYNCEDGE 8'h22
`define CCDTG_A_HALVE 8'h30
`define CCDTG_A_FIRST 8'h31
`define CCDTG_A_SECOND 8'h32
`define CCDTG_A_LAST 8'h33
`define CCDTG_A_RGATE 8'h34
`define CCDTG_A_BLANK 8'h35
`define CCDTG_A_DRIVE 8'h36
`define CCDTG_A_STATUS 8'h3f
`define CCDTG_LRISE_HI 12
`define CCDTG_LRISE_LO 0
`define CCDTG_FRISE_HI 24
`define CCDTG_FRISE_LO 13
`define CCDTG_RISE_HI 5
`define CCDTG_RISE_LO 0
`define CCDTG_FALL_HI 13
`define CCDTG_FALL_LO 8
`define CCDTG_POL_BIT 16
`define CCDTG_B_RT_FIRST 0
`define CCDTG_B_RT_SECOND 1
`define CCDTG_B_RT_LAST 2
`define CCDTG_B_LAST_EN 3
`define CCDTG_B_DIV_HI 6
`define CCDTG_B_DIV_LO 4
`define CCDTG_EDGE_RST 13'h1500
`define CCDTG_RGATE_RST 13'h1280
`define CCDTG_DRIVE_RST 24'h111111
`define CCDTG_STEP_LAST 6'h3f
`define CCDTG_ADDR_LAST 5'h07
`define CCDTG_DATA_BITS 5'h19
`define CCDTG_LINE_PIXELS 8192
`define CCDTG_FIELD_LINES 4096
`endif

// >>> rtl/ccdtg_hclk.sv
// one horizontal clock with edge placement, polarity and blanking divider
`timescale 1ns/1ps
`include "ccdtg_defs.svh"
module ccdtg_hclk
   import ccdtg_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic stepTick,
   input wire logic [5:0] phase,
   input wire ccdtg_edge_t cfg,
   input wire logic blank,
   input wire logic divActive,
   input wire logic divLevel,
   output logic clkOut,
   output logic clkOutN
);
   logic level_r;
   logic levelNxt;
   logic shaped;

   always_comb
   begin
      levelNxt = level_r;
      if (stepTick && phase == cfg.rise)
         levelNxt = 1'b1;
      else if (stepTick && phase == cfg.fall)
         levelNxt = 1'b0;
      // slow square clock in blanking when divActive, normal edges otherwise
      shaped = (blank && divActive) ? divLevel : levelNxt;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         level_r <= 1'b0;
         clkOut <= 1'b1;
         clkOutN <= 1'b0;
      end
      else if (ce)
      begin
         level_r <= levelNxt;
         // pol zero inverts the convention
         clkOut <= shaped ^ ~cfg.pol;
         clkOutN <= ~(shaped ^ ~cfg.pol);
      end
   end
endmodule

// >>> rtl/ccdtg_pkg.sv
// types shared by the timing core modules
package ccdtg_pkg;
`include "ccdtg_defs.svh"
   typedef struct packed {
      logic pol;
      logic [5:0] fall;
      logic [5:0] rise;
   } ccdtg_edge_t;
   typedef struct packed {
      logic valid;
      logic [`CCDTG_AW-1:0] addr;
      logic [`CCDTG_DW-1:0] data;
   } ccdtg_wr_t;
   typedef enum logic [2:0] {
      SER_IDLE = 3'b001,
      SER_ADDR = 3'b010,
      SER_DATA = 3'b100
   } ccdtg_ser_t;
endpackage

// >>> rtl/ccdtg_serial.sv
// three-wire serial register port with readback
`timescale 1ns/1ps
`include "ccdtg_defs.svh"
module ccdtg_serial
   import ccdtg_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic serClk,
   input wire logic serData,
   input wire logic serLoadN,
   input wire logic [`CCDTG_DW-1:0] rdData,
   output logic [`CCDTG_AW-1:0] rdAddr,
   output logic serOut,
   output ccdtg_wr_t wr
);
   ccdtg_ser_t state_r;
   logic serClkPrev_r;
   logic loaded_r;
   logic [4:0] bitCnt_r;
   logic [`CCDTG_DW-1:0] data_r;
   logic [`CCDTG_DW-1:0] shOut_r;
   logic serRise;

   assign serRise = serClk & ~serClkPrev_r;

   always_ff @(posedge mclk)
   begin
      if (rst)
         serClkPrev_r <= 1'b0;
      else if (ce)
         serClkPrev_r <= serClk;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         state_r <= SER_IDLE;
         loaded_r <= 1'b0;
         bitCnt_r <= 5'h00;
         rdAddr <= 8'h00;
         data_r <= 25'h0000000;
         shOut_r <= 25'h0000000;
         serOut <= 1'b0;
         wr <= '0;
      end
      else if (ce)
      begin
         wr.valid <= 1'b0;
         case (state_r)
            SER_IDLE:
            begin
               if (!serLoadN)
               begin
                  state_r <= SER_ADDR;
                  bitCnt_r <= 5'h00;
                  data_r <= 25'h0000000;
                  loaded_r <= 1'b0;
               end
            end
            SER_ADDR:
            begin
               if (serLoadN)
                  state_r <= SER_IDLE;
               else if (serRise)
               begin
                  rdAddr <= {serData, rdAddr[`CCDTG_AW-1:1]};
                  if (bitCnt_r == `CCDTG_ADDR_LAST)
                  begin
                     state_r <= SER_DATA;
                     bitCnt_r <= 5'h00;
                  end
                  else
                     bitCnt_r <= bitCnt_r + 5'h01;
               end
            end
            SER_DATA:
            begin
               if (serLoadN)
               begin
                  // write lands when the frame closes
                  wr.valid <= 1'b1;
                  wr.addr <= rdAddr;
                  wr.data <= data_r;
                  serOut <= 1'b0;
                  state_r <= SER_IDLE;
               end
               else if (!loaded_r)
               begin
                  shOut_r <= rdData;
                  serOut <= rdData[0];
                  loaded_r <= 1'b1;
               end
               else if (serRise && bitCnt_r < `CCDTG_DATA_BITS)
               begin
                  data_r[bitCnt_r] <= serData;
                  shOut_r <= shOut_r >> 1;
                  serOut <= shOut_r[1];
                  bitCnt_r <= bitCnt_r + 5'h01;
               end
            end
            default:
               state_r <= SER_IDLE;
         endcase
      end
   end
endmodule

// >>> rtl/ccdtg_top.sv
// sync generator and horizontal clock timing core
`timescale 1ns/1ps
`include "ccdtg_defs.svh"
module ccdtg_top
   import ccdtg_pkg::*;
#(
   parameter int LINE_PIXELS = `CCDTG_LINE_PIXELS,
   parameter int FIELD_LINES = `CCDTG_FIELD_LINES
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic serClk,
   input wire logic serData,
   input wire logic serLoadN,
   output logic serOut,
   input wire logic lineSyncIn,
   output logic lineSyncOut,
   output logic lineSyncOe,
   input wire logic fieldSyncIn,
   output logic fieldSyncOut,
   output logic fieldSyncOe,
   input wire logic horizontalBlanking,
   output logic firstPairClockA,
   output logic firstPairClockB,
   output logic secondPairClockA,
   output logic secondPairClockB,
   output logic lastStageClock,
   output logic resetGateClock
);
   ccdtg_wr_t wr;
   logic [`CCDTG_AW-1:0] rdAddr;
   logic [`CCDTG_DW-1:0] rdData;
   logic syncMaster_r;
   logic syncActiveLevel_r;
   logic inputHalve_r;
   logic updateHold_r;
   logic [11:0] updateLine_r;
   logic [23:0] driveCode_r;
   ccdtg_edge_t firstCfg_r;
   ccdtg_edge_t secondCfg_r;
   ccdtg_edge_t lastCfg_r;
   ccdtg_edge_t gateCfg_r;
   logic [`CCDTG_DW-1:0] syncEdgeWork_r;
   logic [`CCDTG_DW-1:0] syncEdgePend_r;
   logic [6:0] blankWork_r;
   logic [6:0] blankPend_r;
   logic pending_r;
   logic halfTog_r;
   logic [5:0] phase_r;
   logic [12:0] pixCnt_r;
   logic [11:0] lineCnt_r;
   logic lineStart_r;
   logic lineSyncPrev_r;
   logic fieldSyncPrev_r;
   logic blankDly_r;
   logic [2:0] divCnt_r;
   logic divLevel_r;
   logic stepTick;
   logic pixTick;
   logic lineWrap;
   logic lineEdgeIn;
   logic fieldEdgeIn;
   logic applyNow;
   logic firstBlank;
   logic secondBlank;
   logic lastBlank;
   logic [2:0] divCode;

   function automatic logic pickBlank(input logic retime, input logic raw, input logic dly);
      pickBlank = retime ? dly : raw;
   endfunction

   function automatic ccdtg_edge_t toEdge(input logic [`CCDTG_DW-1:0] d);
      toEdge.rise = d[`CCDTG_RISE_HI:`CCDTG_RISE_LO];
      toEdge.fall = d[`CCDTG_FALL_HI:`CCDTG_FALL_LO];
      toEdge.pol = d[`CCDTG_POL_BIT];
   endfunction

   function automatic logic [`CCDTG_DW-1:0] fromEdge(input ccdtg_edge_t e);
      fromEdge = '0;
      fromEdge[`CCDTG_RISE_HI:`CCDTG_RISE_LO] = e.rise;
      fromEdge[`CCDTG_FALL_HI:`CCDTG_FALL_LO] = e.fall;
      fromEdge[`CCDTG_POL_BIT] = e.pol;
   endfunction

   ccdtg_serial serialPort (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .serClk(serClk),
      .serData(serData),
      .serLoadN(serLoadN),
      .rdData(rdData),
      .rdAddr(rdAddr),
      .serOut(serOut),
      .wr(wr)
   );

   // register readback
   always_comb
   begin
      rdData = '0;
      if (rdAddr == `CCDTG_A_UPDLINE)
         rdData[11:0] = updateLine_r;
      else if (rdAddr == `CCDTG_A_HOLD)
         rdData[0] = updateHold_r;
      else if (rdAddr == `CCDTG_A_MODE)
         rdData[0] = syncMaster_r;
      else if (rdAddr == `CCDTG_A_LEVEL)
         rdData[0] = syncActiveLevel_r;
      else if (rdAddr == `CCDTG_A_SYNCEDGE)
         rdData = syncEdgeWork_r;
      else if (rdAddr == `CCDTG_A_HALVE)
         rdData[0] = inputHalve_r;
      else if (rdAddr == `CCDTG_A_FIRST)
         rdData = fromEdge(firstCfg_r);
      else if (rdAddr == `CCDTG_A_SECOND)
         rdData = fromEdge(secondCfg_r);
      else if (rdAddr == `CCDTG_A_LAST)
         rdData = fromEdge(lastCfg_r);
      else if (rdAddr == `CCDTG_A_RGATE)
         rdData = fromEdge(gateCfg_r);
      else if (rdAddr == `CCDTG_A_BLANK)
         rdData[6:0] = blankWork_r;
      else if (rdAddr == `CCDTG_A_DRIVE)
         rdData[23:0] = driveCode_r;
      else if (rdAddr == `CCDTG_A_STATUS)
         rdData[12:0] = {pending_r, lineCnt_r};
   end

   // immediate registers
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         syncMaster_r <= 1'b0;
         syncActiveLevel_r <= 1'b0;
         inputHalve_r <= 1'b0;
         updateHold_r <= 1'b0;
         updateLine_r <= 12'h000;
         driveCode_r <= `CCDTG_DRIVE_RST;
         firstCfg_r <= `CCDTG_EDGE_RST;
         secondCfg_r <= `CCDTG_EDGE_RST;
         lastCfg_r <= `CCDTG_EDGE_RST;
         gateCfg_r <= `CCDTG_RGATE_RST;
      end
      else if (ce && wr.valid)
      begin
         if (wr.addr == `CCDTG_A_MODE)
            syncMaster_r <= wr.data[0];
         else if (wr.addr == `CCDTG_A_LEVEL)
            syncActiveLevel_r <= wr.data[0];
         else if (wr.addr == `CCDTG_A_HALVE)
            inputHalve_r <= wr.data[0];
         else if (wr.addr == `CCDTG_A_HOLD)
            updateHold_r <= wr.data[0];
         else if (wr.addr == `CCDTG_A_UPDLINE)
            updateLine_r <= wr.data[11:0];
         else if (wr.addr == `CCDTG_A_DRIVE)
            driveCode_r <= wr.data[23:0];
         else if (wr.addr == `CCDTG_A_FIRST)
            firstCfg_r <= toEdge(wr.data);
         else if (wr.addr == `CCDTG_A_SECOND)
            secondCfg_r <= toEdge(wr.data);
         else if (wr.addr == `CCDTG_A_LAST)
            lastCfg_r <= toEdge(wr.data);
         else if (wr.addr == `CCDTG_A_RGATE)
            gateCfg_r <= toEdge(wr.data);
      end
   end

   // field-updated registers: staged, applied at the update line
   assign applyNow = lineStart_r && (lineCnt_r == updateLine_r) && !updateHold_r;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         syncEdgePend_r <= 25'h0000000;
         syncEdgeWork_r <= 25'h0000000;
         blankPend_r <= 7'h00;
         blankWork_r <= 7'h00;
         pending_r <= 1'b0;
      end
      else if (ce)
      begin
         if (applyNow && pending_r)
         begin
            syncEdgeWork_r <= syncEdgePend_r;
            blankWork_r <= blankPend_r;
            pending_r <= 1'b0;
         end
         // a write in the apply cycle stays pending
         if (wr.valid && wr.addr == `CCDTG_A_SYNCEDGE)
         begin
            syncEdgePend_r <= wr.data;
            pending_r <= 1'b1;
         end
         else if (wr.valid && wr.addr == `CCDTG_A_BLANK)
         begin
            blankPend_r <= wr.data[6:0];
            pending_r <= 1'b1;
         end
      end
   end

   // step and pixel timing
   assign stepTick = !inputHalve_r || halfTog_r;
   assign pixTick = stepTick && (phase_r == `CCDTG_STEP_LAST);
   assign lineWrap = pixTick && (pixCnt_r == 13'(LINE_PIXELS - 1));
   assign lineEdgeIn = (lineSyncIn == syncActiveLevel_r) && (lineSyncPrev_r != syncActiveLevel_r);
   assign fieldEdgeIn = (fieldSyncIn == syncActiveLevel_r) && (fieldSyncPrev_r != syncActiveLevel_r);

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         halfTog_r <= 1'b0;
         phase_r <= 6'h00;
      end
      else if (ce)
      begin
         halfTog_r <= ~halfTog_r;
         if (stepTick)
            phase_r <= phase_r + 6'h01;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         pixCnt_r <= 13'h0000;
         lineCnt_r <= 12'h000;
         lineStart_r <= 1'b0;
         lineSyncPrev_r <= 1'b0;
         fieldSyncPrev_r <= 1'b0;
      end
      else if (ce)
      begin
         lineSyncPrev_r <= lineSyncIn;
         fieldSyncPrev_r <= fieldSyncIn;
         lineStart_r <= 1'b0;
         if (!syncMaster_r && fieldEdgeIn)
         begin
            // slave: outside sync restarts the counters
            lineCnt_r <= 12'h000;
            pixCnt_r <= 13'h0000;
            lineStart_r <= 1'b1;
         end
         else if (!syncMaster_r && lineEdgeIn)
         begin
            lineCnt_r <= lineCnt_r + 12'h001;
            pixCnt_r <= 13'h0000;
            lineStart_r <= 1'b1;
         end
         else if (lineWrap)
         begin
            pixCnt_r <= 13'h0000;
            lineStart_r <= 1'b1;
            if (lineCnt_r == 12'(FIELD_LINES - 1))
               lineCnt_r <= 12'h000;
            else
               lineCnt_r <= lineCnt_r + 12'h001;
         end
         else if (pixTick)
            pixCnt_r <= pixCnt_r + 13'h0001;
      end
   end

   // sync pins: driven in master, released in slave
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         lineSyncOut <= 1'b1;
         fieldSyncOut <= 1'b1;
         lineSyncOe <= 1'b1;
         fieldSyncOe <= 1'b1;
      end
      else if (ce)
      begin
         lineSyncOe <= ~syncMaster_r;
         fieldSyncOe <= ~syncMaster_r;
         if (syncMaster_r && pixCnt_r == syncEdgeWork_r[`CCDTG_LRISE_HI:`CCDTG_LRISE_LO])
            lineSyncOut <= syncActiveLevel_r;
         else
            lineSyncOut <= ~syncActiveLevel_r;
         if (syncMaster_r && lineCnt_r == syncEdgeWork_r[`CCDTG_FRISE_HI:`CCDTG_FRISE_LO])
            fieldSyncOut <= syncActiveLevel_r;
         else
            fieldSyncOut <= ~syncActiveLevel_r;
      end
   end

   // blanking retime and slow clock divider
   assign firstBlank = pickBlank(blankWork_r[`CCDTG_B_RT_FIRST], horizontalBlanking, blankDly_r);
   assign secondBlank = pickBlank(blankWork_r[`CCDTG_B_RT_SECOND], horizontalBlanking, blankDly_r);
   assign lastBlank = blankWork_r[`CCDTG_B_LAST_EN] &&
      pickBlank(blankWork_r[`CCDTG_B_RT_LAST], horizontalBlanking, blankDly_r);
   assign divCode = blankWork_r[`CCDTG_B_DIV_HI:`CCDTG_B_DIV_LO];

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         blankDly_r <= 1'b0;
         divCnt_r <= 3'h0;
         divLevel_r <= 1'b0;
      end
      else if (ce && pixTick)
      begin
         blankDly_r <= horizontalBlanking;
         if (!(firstBlank || secondBlank || lastBlank))
         begin
            divCnt_r <= 3'h0;
            divLevel_r <= 1'b0;
         end
         else if (divCnt_r >= divCode - 3'h1)
         begin
            // half period of code pixels
            divCnt_r <= 3'h0;
            divLevel_r <= ~divLevel_r;
         end
         else
            divCnt_r <= divCnt_r + 3'h1;
      end
   end

   ccdtg_hclk firstPair (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .stepTick(stepTick),
      .phase(phase_r),
      .cfg(firstCfg_r),
      .blank(firstBlank),
      .divActive(divCode != 3'h0),
      .divLevel(divLevel_r),
      .clkOut(firstPairClockA),
      .clkOutN(firstPairClockB)
   );

   ccdtg_hclk secondPair (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .stepTick(stepTick),
      .phase(phase_r),
      .cfg(secondCfg_r),
      .blank(secondBlank),
      .divActive(divCode != 3'h0),
      .divLevel(divLevel_r),
      .clkOut(secondPairClockA),
      .clkOutN(secondPairClockB)
   );

   ccdtg_hclk lastStage (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .stepTick(stepTick),
      .phase(phase_r),
      .cfg(lastCfg_r),
      .blank(lastBlank),
      .divActive(divCode != 3'h0),
      .divLevel(divLevel_r),
      .clkOut(lastStageClock),
      .clkOutN()
   );

   ccdtg_hclk resetGate (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .stepTick(stepTick),
      .phase(phase_r),
      .cfg(gateCfg_r),
      .blank(1'b0),
      .divActive(1'b0),
      .divLevel(1'b0),
      .clkOut(resetGateClock),
      .clkOutN()
   );
endmodule

// >>> sim/ccdtg_monitor.sv
// assertion checker on the timing core ports
`timescale 1ns/1ps
module ccdtg_monitor
#(
   parameter int LINE_PIXELS = 8192,
   parameter int FIELD_LINES = 4096
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic serLoadN,
   input wire logic serOut,
   input wire logic lineSyncOut,
   input wire logic lineSyncOe,
   input wire logic fieldSyncOut,
   input wire logic fieldSyncOe,
   input wire logic firstPairClockA,
   input wire logic firstPairClockB,
   input wire logic secondPairClockA,
   input wire logic secondPairClockB,
   input wire logic lastStageClock,
   input wire logic resetGateClock
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   sequence s_reset;
      rst && ce;
   endsequence
   sequence s_line_edge;
      !lineSyncOe && !$past(lineSyncOe) && $changed(lineSyncOut);
   endsequence
   sequence s_field_edge;
      !fieldSyncOe && !$past(fieldSyncOe) && $changed(fieldSyncOut);
   endsequence
   a_reset_clocks:
      assert property (disable iff (1'b0) s_reset |=> firstPairClockA && !firstPairClockB
         && secondPairClockA && lastStageClock && resetGateClock)
      else $error("clock outputs wrong after reset");
   a_reset_sync:
      assert property (disable iff (1'b0) s_reset |=> lineSyncOe && fieldSyncOe
         && lineSyncOut && fieldSyncOut && !serOut)
      else $error("sync pins wrong after reset");
   a_first_pair:
      assert property ($rose(firstPairClockA) |-> $fell(firstPairClockB))
      else $error("first pair not complementary");
   a_second_pair:
      assert property ($changed(secondPairClockA) |-> secondPairClockB == !secondPairClockA)
      else $error("second pair not complementary");
   a_slave_level:
      assert property (lineSyncOe && $past(lineSyncOe) |-> fieldSyncOe
         && lineSyncOut == fieldSyncOut)
      else $error("released sync pins disagree");
   a_line_width:
      assert property (s_line_edge |=> $stable(lineSyncOut)[*8])
      else $error("line sync pulse too short");
   a_field_width:
      assert property (s_field_edge |=> $stable(fieldSyncOut)[*8])
      else $error("field sync pulse too short");
   a_ce_freeze:
      assert property (!ce |=> $stable(firstPairClockA) && $stable(resetGateClock)
         && $stable(lineSyncOut))
      else $error("outputs moved while disabled");
   a_serout_idle:
      assert property (serLoadN[*3] |-> !serOut)
      else $error("readback active outside frame");
endmodule

// >>> sim/ccdtg_sensor_model.sv
// sensor side model: outside line and field sync source
`timescale 1ns/1ps
module ccdtg_sensor_model
#(
   parameter int FIELD_LINES = 4
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic activeLevel,
   input wire logic [15:0] linePeriod,
   output logic lineSyncIn,
   output logic fieldSyncIn
);
   int tick = 0;
   int line = 0;
   always @(posedge mclk)
   begin
      if (rst || tick >= linePeriod - 1)
      begin
         tick <= 0;
         line <= (rst || line >= FIELD_LINES - 1) ? 0 : line + 1;
      end
      else
         tick <= tick + 1;
      lineSyncIn <= (tick < 4) ? activeLevel : !activeLevel;
      fieldSyncIn <= (line == 0 && tick >= 256 && tick < 260) ? activeLevel : !activeLevel;
   end
endmodule

// >>> sim/ccdtg_top_tb.sv
// self-checking bench for the sync and horizontal clock core
`timescale 1ns/1ps
module ccdtg_top_tb;
   localparam int LP = 8;
   localparam int FL = 4;
   localparam int FIELD = LP * 64 * FL;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic serClk = 1'b0;
   logic serData = 1'b0;
   logic serLoadN = 1'b1;
   logic hBlank = 1'b0;
   logic lvl = 1'b0;
   logic [15:0] lp = 16'h0200;
   logic lsIn, fsIn, serOut, lsOut, lsOe, fsOut, fsOe, c1a, c1b, c2a, c2b, cl, crg;
   logic [5:0] hc;
   logic [24:0] q;
   logic [24:0] wv;
   logic [7:0] ra [11] = '{8'h20, 8'h21, 8'h22, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35,
      8'h36, 8'h7f};
   logic [24:0] rv [11] = '{25'h0, 25'h0, 25'h0, 25'h0, 25'h11400, 25'h11400, 25'h11400,
      25'h10a00, 25'h0, 25'h111111, 25'h0};
   int expHi [4] = '{20, 20, 20, 10};
   int fails = 0;
   int num_checks = 0;
   int seed = 21;
   int hi, per, r, f, n;
   always #5 mclk = ~mclk;
   assign hc = {fsOut, lsOut, crg, cl, c2a, c1a};
   ccdtg_top #(.LINE_PIXELS(LP), .FIELD_LINES(FL)) u_ccdtg_top (
      .mclk(mclk), .rst(rst), .ce(ce), .serClk(serClk), .serData(serData),
      .serLoadN(serLoadN), .serOut(serOut), .lineSyncIn(lsIn), .lineSyncOut(lsOut),
      .lineSyncOe(lsOe), .fieldSyncIn(fsIn), .fieldSyncOut(fsOut), .fieldSyncOe(fsOe),
      .horizontalBlanking(hBlank), .firstPairClockA(c1a), .firstPairClockB(c1b),
      .secondPairClockA(c2a), .secondPairClockB(c2b), .lastStageClock(cl),
      .resetGateClock(crg)
   );
   ccdtg_sensor_model #(.FIELD_LINES(FL)) u_ccdtg_sensor_model (
      .mclk(mclk), .rst(rst), .activeLevel(lvl), .linePeriod(lp), .lineSyncIn(lsIn),
      .fieldSyncIn(fsIn)
   );
   task automatic end_of_test;
      if (fails == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // serial frame: address then data, lsb first; readback lands in q
   task automatic tx(input logic [7:0] a, input logic [24:0] d);
      logic [32:0] w;
      w = {d, a};
      @(posedge mclk) serLoadN <= 1'b0;
      for (int i = 0; i < 33; i++)
      begin
         @(posedge mclk) serClk <= 1'b0;
         serData <= w[i];
         @(posedge mclk);
         @(posedge mclk) serClk <= 1'b1;
         if (i >= 8)
            q[i - 8] = serOut;
      end
      @(posedge mclk) serClk <= 1'b0;
      @(posedge mclk) serLoadN <= 1'b1;
      repeat (3) @(posedge mclk);
   endtask
   task automatic step(inout int g, inout int c);
      @(posedge mclk);
      g++;
      c++;
   endtask
   // high time and period of one watched output, in mclk cycles
   task automatic meas(input int k);
      int g;
      int z;
      g = 0;
      z = 0;
      hi = 0;
      while (hc[k] !== 1'b0 && g < 5000) step(g, z);
      while (hc[k] !== 1'b1 && g < 5000) step(g, z);
      while (hc[k] === 1'b1 && g < 5000) step(g, hi);
      per = hi;
      while (hc[k] !== 1'b1 && g < 5000) step(g, per);
      if (g >= 5000)
         fails++;
   endtask
   initial
   begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk) ce <= 1'b0;
      repeat (4) @(posedge mclk);
      ce <= 1'b1;
      for (int i = 0; i < 11; i++)
      begin
         tx(ra[i], rv[i]);
         check(q, rv[i]);
      end
      for (int k = 0; k < 4; k++)
      begin
         meas(k);
         check(hi, expHi[k]);
         check(per, 64);
      end
      check(c1b, !c1a);
      check(c2b, !c2a);
      for (int k = 0; k < 4; k++)
      begin
         r = {$random(seed)} % 31;
         f = r + 1 + {$random(seed)} % 32;
         n = {$random(seed)} % 2;
         expHi[k] = n ? f - r : 64 - f + r;
         wv = 25'(n * 65536 + f * 256 + r);
         tx(8'(8'h31 + k), wv);
         tx(8'(8'h31 + k), wv);
         check(q, wv);
         meas(k);
         check(hi, expHi[k]);
      end
      tx(8'h30, 25'h1);
      meas(0);
      check(hi, 2 * expHi[0]);
      check(per, 128);
      tx(8'h30, 25'h0);
      tx(8'h18, 25'h2);
      tx(8'h19, 25'h1);
      hBlank <= 1'b1;
      lp <= 16'h0400;
      tx(8'h35, 25'h19);
      repeat (2 * FIELD + 600) @(posedge mclk);
      meas(2);
      check(per, 64);
      lp <= 16'h0200;
      tx(8'h19, 25'h0);
      repeat (FIELD + 600) @(posedge mclk);
      meas(2);
      check(per, 128);
      for (int c = 0; c < 8; c++)
      begin
         tx(8'h35, 25'(c * 16 + (c % 2) * 8 + 7));
         repeat (FIELD + 600) @(posedge mclk);
         meas(0);
         check(per, (c == 0) ? 64 : 128 * c);
         meas(1);
         check(per, (c == 0) ? 64 : 128 * c);
         meas(2);
         check(per, (c % 2 == 1) ? 128 * c : 64);
      end
      hBlank <= 1'b0;
      lvl <= 1'b1;
      tx(8'h22, 25'h2003);
      tx(8'h21, 25'h1);
      // new edges land first, so no driven pulse is cut short
      repeat (FIELD + 600) @(posedge mclk);
      tx(8'h20, 25'h1);
      repeat (600) @(posedge mclk);
      check(lsOe, 1'b0);
      check(fsOe, 1'b0);
      meas(4);
      check(hi, 64);
      check(per, LP * 64);
      meas(5);
      check(hi, LP * 64);
      check(per, FIELD);
      n = 0;
      while (lsOut !== 1'b1 && n < 600) step(n, r);
      check((n + 32) / 64, 3);
      end_of_test;
   end
   initial
   begin
      repeat (95000) @(posedge mclk);
      fails++;
      end_of_test;
   end
endmodule
bind ccdtg_top ccdtg_monitor #(.LINE_PIXELS(LINE_PIXELS), .FIELD_LINES(FIELD_LINES)) u_mon (
   .mclk(mclk), .rst(rst), .ce(ce), .serLoadN(serLoadN), .serOut(serOut),
   .lineSyncOut(lineSyncOut), .lineSyncOe(lineSyncOe), .fieldSyncOut(fieldSyncOut),
   .fieldSyncOe(fieldSyncOe), .firstPairClockA(firstPairClockA),
   .firstPairClockB(firstPairClockB), .secondPairClockA(secondPairClockA),
   .secondPairClockB(secondPairClockB), .lastStageClock(lastStageClock),
   .resetGateClock(resetGateClock)
);
